// ---- hw/dpsm_pkg.sv ----
// dpsm_pkg: register map, field positions and reset values
// assumes word-indexed registers, byte address is four times the index
package dpsm_pkg;

  localparam int          NUM_CH        = 4;
  localparam int          ADDR_W        = 16;

  // register indices, byte address = index * 4
  localparam logic [11:0] IDX_IO_UPDATE = 12'h005;
  localparam logic [11:0] IDX_ANALOG_CTRL = 12'h405;
  localparam logic [11:0] IDX_PRESC_PWR = 12'h408;
  localparam logic [11:0] IDX_SYNC_CTRL = 12'h500;
  localparam logic [11:0] IDX_DRV_EN    = 12'h600;
  localparam logic [11:0] IDX_STATUS    = 12'h601;

  // prescaler divider power register
  localparam int          PWR_START_BIT = 4;
  localparam int          PWR_DUAL_BIT  = 2;
  localparam int          PWR_P2_BIT    = 1;
  localparam int          PWR_P1_BIT    = 0;
  localparam logic [7:0]  PWR_RST       = 8'h02;
  localparam logic [7:0]  PWR_WMASK     = 8'h17;

  // output channel sync control register
  localparam int          SYNC_MASK_LSB = 4;
  localparam int          SYNC_SRC_BIT  = 2;
  localparam int          SYNC_AUTO_LSB = 0;
  localparam logic [7:0]  SYNC_RST      = 8'h02;
  localparam logic [7:0]  SYNC_WMASK    = 8'hF7;

  // analog loop control register, only the sync bypass bit is held
  localparam int          ANALOG_SYNC_BIT = 3;
  localparam logic [7:0]  ANALOG_RST      = 8'h00;
  localparam logic [7:0]  ANALOG_WMASK    = 8'h08;

  localparam int          IO_UPD_BIT    = 0;
  localparam logic [7:0]  DRV_RST       = 8'h00;
  localparam logic [7:0]  DRV_WMASK     = 8'h0F;

  typedef enum logic [1:0] {
    AUTO_OFF   = 2'b00,
    AUTO_FREQ  = 2'b01,
    AUTO_PHASE = 2'b10,
    AUTO_RSVD  = 2'b11
  } dpsm_auto_type;

  typedef enum logic [1:0] {
    ST_HOLD = 2'b01,
    ST_FREE = 2'b10
  } dpsm_start_type;

  // write only the implemented bits, the rest keep their value
  function automatic logic [7:0] dpsm_merge(input logic [7:0] old_v,
                                            input logic [7:0] new_v,
                                            input logic [7:0] wmask);
    dpsm_merge = (old_v & ~wmask) | (new_v & wmask);
  endfunction : dpsm_merge

endpackage : dpsm_pkg

// ---- hw/dpsm_chan.sv ----
// dpsm_chan: run and sync-reset state of one output channel divider
// assumes the mask value that will be stored at this edge on nxt_mask_in
`timescale 1ns/1ps
`default_nettype none
module dpsm_chan (
  input  wire logic clk_in,        // block clock
  input  wire logic rst_n_in,      // async reset, active low
  input  wire logic nxt_mask_in,   // mask bit as stored at this edge
  input  wire logic sync_in,       // gated sync event
  output logic      run_out,       // divider may toggle
  output logic      sync_rst_out   // one-cycle divider sync reset
);

  logic run_ff;
  logic nxt_run;
  logic srst_ff;
  logic nxt_srst;

  always_comb begin
    nxt_srst = sync_in & ~nxt_mask_in;
    nxt_run  = run_ff | nxt_mask_in | nxt_srst;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      run_ff  <= 1'b0;
      srst_ff <= 1'b0;
    end else begin
      run_ff  <= nxt_run;
      srst_ff <= nxt_srst;
    end
  end

  assign run_out      = run_ff;
  assign sync_rst_out = srst_ff;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_static_hold;
    !sync_in && !nxt_mask_in && !run_ff |=> !run_ff;
  endproperty
  a_static_hold: assert property (p_static_hold) else $error("channel left static state");

  property p_mask_release;
    nxt_mask_in |=> run_ff && !srst_ff;
  endproperty
  a_mask_release: assert property (p_mask_release) else $error("mask did not release");

  property p_mask_ignore;
    nxt_mask_in && sync_in |=> !srst_ff;
  endproperty
  a_mask_ignore: assert property (p_mask_ignore) else $error("masked channel synced");

endmodule : dpsm_chan
`default_nettype wire

// ---- hw/dpsm_top.sv ----
// dpsm_top: prescaler power-down and output channel sync mask control
// assumes an APB master on CLOCK_IN; status pins arrive asynchronously
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module dpsm_top
  import dpsm_pkg::*;
(
  input  wire logic              CLOCK_IN,        // 50 MHz clock
  input  wire logic              RST_N_IN,        // async reset, active low
  input  wire logic              PSEL_IN,         // apb select
  input  wire logic              PENABLE_IN,      // apb enable
  input  wire logic              PWRITE_IN,       // apb write
  input  wire logic [ADDR_W-1:0] PADDR_IN,        // apb byte address
  input  wire logic [31:0]       PWDATA_IN,       // apb write data
  output logic      [31:0]       PRDATA_OUT,      // apb read data
  output logic                   PREADY_OUT,      // apb ready
  output logic                   PSLVERR_OUT,     // apb error
  input  wire logic              FB_DETECT_IN,    // analog loop feedback seen
  input  wire logic              ANALOG_LOCK_IN,  // analog loop calibrated, locked
  input  wire logic              FREQ_LOCK_IN,    // digital loop frequency lock
  input  wire logic              PHASE_LOCK_IN,   // digital loop phase lock
  input  wire logic              REF_SYNC_IN,     // active reference sync edge
  output logic                   PRESC1_PD_OUT,   // first prescaler powered down
  output logic                   PRESC2_PD_OUT,   // second prescaler powered down
  output logic      [NUM_CH-1:0] CHAN_RUN_OUT,    // channel divider may toggle
  output logic      [NUM_CH-1:0] CHAN_SYNC_OUT,   // channel sync reset pulse
  output logic      [NUM_CH-1:0] CHAN_DRV_EN_OUT  // channel driver enable
);

  localparam int NSYNC = 5;

  // apb slave state
  logic        pready_ff;
  logic        nxt_pready;
  logic        pslverr_ff;
  logic        nxt_pslverr;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;

  // registers
  logic [7:0]  pwr_ff;
  logic [7:0]  nxt_pwr;
  logic [7:0]  sync_ff;
  logic [7:0]  nxt_sync;
  logic [7:0]  analog_ff;
  logic [7:0]  nxt_analog;
  logic [7:0]  drv_ff;
  logic [7:0]  nxt_drv;

  // pin synchronisers and edge history
  logic [NSYNC-1:0] s1_ff;
  logic [NSYNC-1:0] s2_ff;
  logic [NSYNC-1:0] s3_ff;

  dpsm_start_type st_ff;
  dpsm_start_type nxt_st;
  logic        pd1_ff;
  logic        nxt_pd1;
  logic        pd2_ff;
  logic        nxt_pd2;

  logic [11:0] idx;
  logic        hit;
  logic        setup;
  logic        wr_go;
  logic        io_upd;
  logic        fb_s;
  logic        analog_lock_s;
  logic        frq_rise;
  logic        phs_rise;
  logic        ref_rise;
  logic        sync_gate;
  logic        src_evt;
  logic        auto_evt;
  logic        sync_evt;
  logic        hold_on;
  logic [3:0]  mask_w;
  logic [7:0]  status_w;

  assign idx   = PADDR_IN[13:2];
  assign setup = PSEL_IN & ~PENABLE_IN;
  assign wr_go = PSEL_IN & PENABLE_IN & PWRITE_IN & pready_ff & ~pslverr_ff;

  always_comb begin
    unique case (idx)
      IDX_IO_UPDATE,
      IDX_ANALOG_CTRL,
      IDX_PRESC_PWR,
      IDX_SYNC_CTRL,
      IDX_DRV_EN,
      IDX_STATUS:    hit = (PADDR_IN[15:14] == 2'h0) && (PADDR_IN[1:0] == 2'h0);
      default:       hit = 1'b0;
    endcase
  end

  // apb: no wait states, answer in the access phase
  always_comb begin
    nxt_pready  = setup;
    nxt_pslverr = setup & ~hit;
    nxt_prdata  = prdata_ff;
    if (setup) begin
      nxt_prdata = 32'h0000_0000;
      if (hit && !PWRITE_IN) begin
        unique case (idx)
          IDX_ANALOG_CTRL: nxt_prdata = {24'h00_0000, analog_ff};
          IDX_PRESC_PWR: nxt_prdata = {24'h00_0000, pwr_ff};
          IDX_SYNC_CTRL: nxt_prdata = {24'h00_0000, sync_ff};
          IDX_DRV_EN:    nxt_prdata = {24'h00_0000, drv_ff};
          IDX_STATUS:    nxt_prdata = {24'h00_0000, status_w};
          default:       nxt_prdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff  <= nxt_prdata;
    end
  end

  // register writes
  always_comb begin
    nxt_pwr    = pwr_ff;
    nxt_sync   = sync_ff;
    nxt_analog = analog_ff;
    nxt_drv    = drv_ff;
    if (wr_go) begin
      unique case (idx)
        IDX_PRESC_PWR: nxt_pwr  = dpsm_merge(pwr_ff, PWDATA_IN[7:0], PWR_WMASK);
        IDX_SYNC_CTRL: nxt_sync = dpsm_merge(sync_ff, PWDATA_IN[7:0], SYNC_WMASK);
        IDX_ANALOG_CTRL: nxt_analog = dpsm_merge(analog_ff, PWDATA_IN[7:0], ANALOG_WMASK);
        IDX_DRV_EN:    nxt_drv  = dpsm_merge(drv_ff, PWDATA_IN[7:0], DRV_WMASK);
        default:       nxt_pwr  = pwr_ff;
      endcase
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pwr_ff  <= PWR_RST;
      sync_ff <= SYNC_RST;
      analog_ff <= ANALOG_RST;
      drv_ff  <= DRV_RST;
    end else begin
      pwr_ff  <= nxt_pwr;
      sync_ff <= nxt_sync;
      analog_ff <= nxt_analog;
      drv_ff  <= nxt_drv;
    end
  end

  // two-flop synchronisers, third stage only for edge detection
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= {REF_SYNC_IN, PHASE_LOCK_IN, FREQ_LOCK_IN, ANALOG_LOCK_IN, FB_DETECT_IN};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  assign fb_s          = s2_ff[0];
  assign analog_lock_s = s2_ff[1];
  assign frq_rise      = s2_ff[2] & ~s3_ff[2];
  assign phs_rise      = s2_ff[3] & ~s3_ff[3];
  assign ref_rise      = s2_ff[4] & ~s3_ff[4];

  // start-up hold of the prescalers
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      ST_HOLD: if (fb_s) begin
        nxt_st = ST_FREE;
      end
      ST_FREE: nxt_st = ST_FREE;
      default: nxt_st = ST_HOLD;
    endcase
  end

  always_comb begin
    hold_on = (nxt_st == ST_HOLD) & ~nxt_pwr[PWR_START_BIT];
    nxt_pd1 = nxt_pwr[PWR_P1_BIT] | nxt_pwr[PWR_DUAL_BIT] | hold_on;
    nxt_pd2 = nxt_pwr[PWR_P2_BIT] | nxt_pwr[PWR_DUAL_BIT] | hold_on;
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      st_ff  <= ST_HOLD;
      pd1_ff <= 1'b1;
      pd2_ff <= 1'b1;
    end else begin
      st_ff  <= nxt_st;
      pd1_ff <= nxt_pd1;
      pd2_ff <= nxt_pd2;
    end
  end

  // sync event generation
  assign io_upd = wr_go & (idx == IDX_IO_UPDATE) & PWDATA_IN[IO_UPD_BIT];

  always_comb begin
    src_evt = sync_ff[SYNC_SRC_BIT] ? ref_rise : io_upd;
    unique case (dpsm_auto_type'(sync_ff[SYNC_AUTO_LSB +: 2]))
      AUTO_FREQ:  auto_evt = frq_rise;
      AUTO_PHASE: auto_evt = phs_rise;
      default:    auto_evt = 1'b0;
    endcase
    sync_gate = analog_ff[ANALOG_SYNC_BIT] | analog_lock_s;
    sync_evt  = sync_gate & (src_evt | auto_evt);
  end

  assign mask_w   = sync_ff[SYNC_MASK_LSB +: NUM_CH];
  assign status_w = {1'b0, (st_ff == ST_HOLD), pd2_ff, pd1_ff, CHAN_RUN_OUT};

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_chan
      dpsm_chan u_chan (
        .clk_in       (CLOCK_IN),
        .rst_n_in     (RST_N_IN),
        .nxt_mask_in  (nxt_sync[SYNC_MASK_LSB + ch]),
        .sync_in      (sync_evt),
        .run_out      (CHAN_RUN_OUT[ch]),
        .sync_rst_out (CHAN_SYNC_OUT[ch])
      );
    end
  endgenerate

  assign PRDATA_OUT      = prdata_ff;
  assign PREADY_OUT      = pready_ff;
  assign PSLVERR_OUT     = pslverr_ff;
  assign PRESC1_PD_OUT   = pd1_ff;
  assign PRESC2_PD_OUT   = pd2_ff;
  assign CHAN_DRV_EN_OUT = drv_ff[NUM_CH-1:0];

  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_N_IN);

  property p_hold;
    st_ff == ST_HOLD && !pwr_ff[PWR_START_BIT] |-> PRESC1_PD_OUT && PRESC2_PD_OUT;
  endproperty
  a_hold: assert property (p_hold) else $error("prescaler ran during hold");

  property p_no_hold;
    pwr_ff[PWR_START_BIT] && pwr_ff[2:0] == 3'h0 |-> !PRESC1_PD_OUT && !PRESC2_PD_OUT;
  endproperty
  a_no_hold: assert property (p_no_hold) else $error("start-up bit ignored");

  property p_dual;
    pwr_ff[PWR_DUAL_BIT] |-> PRESC1_PD_OUT && PRESC2_PD_OUT;
  endproperty
  a_dual: assert property (p_dual) else $error("dual power-down ignored");

  property p_pd2;
    st_ff == ST_FREE && !pwr_ff[PWR_DUAL_BIT] |-> PRESC2_PD_OUT == pwr_ff[PWR_P2_BIT];
  endproperty
  a_pd2: assert property (p_pd2) else $error("second prescaler wrong");

  property p_pd1;
    st_ff == ST_FREE && !pwr_ff[PWR_DUAL_BIT] |-> PRESC1_PD_OUT == pwr_ff[PWR_P1_BIT];
  endproperty
  a_pd1: assert property (p_pd1) else $error("first prescaler wrong");

  property p_rsvd;
    pwr_ff[7:5] == 3'h0 && !pwr_ff[3];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved power bit set");

  property p_release;
    st_ff == ST_HOLD && fb_s |=> st_ff == ST_FREE;
  endproperty
  a_release: assert property (p_release) else $error("hold not released");

  property p_gate;
    !analog_ff[ANALOG_SYNC_BIT] && !analog_lock_s |=> CHAN_SYNC_OUT == 4'h0;
  endproperty
  a_gate: assert property (p_gate) else $error("sync without analog lock");

  property p_io_sync;
    io_upd && !sync_ff[SYNC_SRC_BIT] && sync_gate |=> CHAN_SYNC_OUT == ~$past(mask_w);
  endproperty
  a_io_sync: assert property (p_io_sync) else $error("update strobe gave no sync");

  property p_auto;
    sync_ff[1:0] == AUTO_OFF && sync_ff[SYNC_SRC_BIT] && !ref_rise |=> CHAN_SYNC_OUT == 4'h0;
  endproperty
  a_auto: assert property (p_auto) else $error("auto sync while off");

  property p_drv;
    wr_go && idx == IDX_SYNC_CTRL |=> $stable(CHAN_DRV_EN_OUT);
  endproperty
  a_drv: assert property (p_drv) else $error("mask touched driver enable");

  c_release: cover property (st_ff == ST_HOLD ##1 st_ff == ST_FREE);
  c_sync:    cover property (CHAN_SYNC_OUT != 4'h0);
  c_unmask:  cover property (!CHAN_RUN_OUT[0] ##1 CHAN_RUN_OUT[0]);
  c_err:     cover property (PSLVERR_OUT && PREADY_OUT);

endmodule : dpsm_top
`default_nettype wire

// ---- tb/tb_dpsm_top.sv ----
// tb_dpsm_top: self-checking bench for the prescaler power and sync mask block
// assumes dpsm_pkg is compiled first; drives APB and status pins directly
`timescale 1ns/1ps
`default_nettype none
module tb_dpsm_top;
  import dpsm_pkg::*;

  localparam logic [15:0] A_PWR = {2'b00, IDX_PRESC_PWR, 2'b00};
  localparam logic [15:0] A_SYN = {2'b00, IDX_SYNC_CTRL, 2'b00};
  localparam logic [15:0] A_APL = {2'b00, IDX_ANALOG_CTRL, 2'b00};
  localparam logic [15:0] A_STS = {2'b00, IDX_STATUS, 2'b00};
  localparam logic [15:0] A_UPD = {2'b00, IDX_IO_UPDATE, 2'b00};
  localparam logic [15:0] A_DRV = {2'b00, IDX_DRV_EN, 2'b00};
  localparam logic [15:0] A_BAD = 16'h0FFC;

  logic        CLOCK_IN, RST_N_IN, PSEL_IN, PENABLE_IN, PWRITE_IN;
  logic [15:0] PADDR_IN;
  logic [31:0] PWDATA_IN, PRDATA_OUT;
  logic        PREADY_OUT, PSLVERR_OUT, FB_DETECT_IN, ANALOG_LOCK_IN;
  logic        FREQ_LOCK_IN, PHASE_LOCK_IN, REF_SYNC_IN;
  logic        PRESC1_PD_OUT, PRESC2_PD_OUT;
  logic [3:0]  CHAN_RUN_OUT, CHAN_SYNC_OUT, CHAN_DRV_EN_OUT;
  int          mismatches, n_compared, seed;
  logic [3:0]  m, run_exp;
  logic [7:0]  pv [5];
  logic [32:0] apb_q [$];
  logic [3:0]  syn_q [$];

  dpsm_top dut (.CLOCK_IN(CLOCK_IN), .RST_N_IN(RST_N_IN), .PSEL_IN(PSEL_IN),
    .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
    .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
    .PSLVERR_OUT(PSLVERR_OUT), .FB_DETECT_IN(FB_DETECT_IN), .ANALOG_LOCK_IN(ANALOG_LOCK_IN),
    .FREQ_LOCK_IN(FREQ_LOCK_IN), .PHASE_LOCK_IN(PHASE_LOCK_IN),
    .REF_SYNC_IN(REF_SYNC_IN), .PRESC1_PD_OUT(PRESC1_PD_OUT),
    .PRESC2_PD_OUT(PRESC2_PD_OUT), .CHAN_RUN_OUT(CHAN_RUN_OUT),
    .CHAN_SYNC_OUT(CHAN_SYNC_OUT), .CHAN_DRV_EN_OUT(CHAN_DRV_EN_OUT));

  initial begin
    CLOCK_IN = 1'b0;
    forever #10 CLOCK_IN = ~CLOCK_IN;
  end

  task automatic end_sim;
    if (mismatches == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one APB transfer; exp is {error, read data} noted for the monitor
  task automatic apb(input logic wr, input logic [15:0] a, input logic [7:0] d,
                     input logic [32:0] exp);
    logic [31:0] r;
    r = $random(seed);
    @(posedge CLOCK_IN);
    apb_q.push_back(exp);
    PSEL_IN    <= 1'b1;
    PENABLE_IN <= 1'b0;
    PWRITE_IN  <= wr;
    PADDR_IN   <= a;
    PWDATA_IN  <= {r[31:8], d};
    @(posedge CLOCK_IN);
    PENABLE_IN <= 1'b1;
    // hold the request until pready is seen high at a rising edge
    @(posedge CLOCK_IN);
    while (PREADY_OUT !== 1'b1) @(posedge CLOCK_IN);
    PSEL_IN    <= 1'b0;
    PENABLE_IN <= 1'b0;
  endtask : apb

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] v);
    apb(1'b0, a, 8'h00, {25'h0, v});
  endtask : rd

  task automatic pins(input logic p1, input logic p2, input logic [3:0] run,
                      input logic [3:0] drv);
    @(negedge CLOCK_IN);
    chk(33'({PRESC1_PD_OUT, PRESC2_PD_OUT, CHAN_RUN_OUT, CHAN_DRV_EN_OUT}),
        33'({p1, p2, run, drv}));
  endtask : pins

  task automatic rst;
    RST_N_IN <= 1'b0;
    repeat (5) @(posedge CLOCK_IN);
    RST_N_IN <= 1'b1;
  endtask : rst

  // takes the oldest note whenever a transfer completes or a sync pulse shows
  // sampled at the rising edge, with the values the design samples there
  always @(posedge CLOCK_IN) begin
    if (PSEL_IN && PENABLE_IN && PREADY_OUT === 1'b1)
      chk({PSLVERR_OUT, PWRITE_IN ? 32'h0 : PRDATA_OUT}, apb_q.pop_front());
    if (RST_N_IN && CHAN_SYNC_OUT !== 4'h0) begin
      if (syn_q.size() == 0)
        chk(33'(CHAN_SYNC_OUT), 33'h0);
      else
        chk(33'(CHAN_SYNC_OUT), 33'(syn_q.pop_front()));
    end
  end

  initial begin
    repeat (20000) @(posedge CLOCK_IN);
    mismatches++;
    end_sim();
  end

  initial begin
    seed = 13;
    mismatches = 0;
    n_compared = 0;
    {RST_N_IN, PSEL_IN, PENABLE_IN, PWRITE_IN, FB_DETECT_IN, ANALOG_LOCK_IN} = '0;
    {FREQ_LOCK_IN, PHASE_LOCK_IN, REF_SYNC_IN, PADDR_IN, PWDATA_IN} = '0;
    pv = '{8'h04, 8'h02, 8'h01, 8'h00, 8'hFF};
    rst();
    rd(A_PWR, PWR_RST);
    rd(A_SYN, SYNC_RST);
    rd(A_APL, ANALOG_RST);
    rd(A_DRV, DRV_RST);
    rd(A_STS, 8'h70);
    apb(1'b0, A_BAD, 8'h00, {1'b1, 32'h0});
    apb(1'b1, A_BAD, 8'hFF, {1'b1, 32'h0});
    pins(1'b1, 1'b1, 4'h0, 4'h0);
    wr(A_PWR, 8'h10);
    pins(1'b0, 1'b0, 4'h0, 4'h0);
    wr(A_PWR, 8'h00);
    pins(1'b1, 1'b1, 4'h0, 4'h0);
    @(posedge CLOCK_IN);
    FB_DETECT_IN <= 1'b1;
    repeat (3) @(posedge CLOCK_IN);
    pins(1'b0, 1'b0, 4'h0, 4'h0);
    for (int i = 0; i < 5; i++) begin
      wr(A_PWR, pv[i]);
      pins(pv[i][0] | pv[i][2], pv[i][1] | pv[i][2], 4'h0, 4'h0);
      rd(A_PWR, pv[i] & PWR_WMASK);
    end
    run_exp = 4'h0;
    for (int n = 0; n < NUM_CH; n++) begin
      wr(A_SYN, 8'h10 << n);
      run_exp[n] = 1'b1;
      pins(1'b1, 1'b1, run_exp, 4'h0);
    end
    wr(A_DRV, 8'h0F);
    pins(1'b1, 1'b1, 4'hF, 4'hF);
    for (int i = 0; i < 3; i++) begin
      @(posedge CLOCK_IN);
      FB_DETECT_IN   <= 1'b0;
      ANALOG_LOCK_IN <= 1'b0;
      rst();
      m = 4'($random(seed));
      wr(A_SYN, {m, 4'h0});
      pins(1'b1, 1'b1, m, 4'h0);
      rd(A_STS, {4'h7, m});
      wr(A_UPD, 8'h01);
      pins(1'b1, 1'b1, m, 4'h0);
      if (i == 1) begin
        @(posedge CLOCK_IN);
        ANALOG_LOCK_IN <= 1'b1;
        repeat (4) @(posedge CLOCK_IN);
      end else
        wr(A_APL, 8'h08);
      if (m != 4'hF) syn_q.push_back(~m);
      wr(A_UPD, 8'h01);
      pins(1'b1, 1'b1, 4'hF, 4'h0);
    end
    m[0] = 1'b0;
    for (int md = 0; md < 4; md++) begin
      @(posedge CLOCK_IN);
      FREQ_LOCK_IN  <= 1'b0;
      PHASE_LOCK_IN <= 1'b0;
      repeat (4) @(posedge CLOCK_IN);
      wr(A_SYN, {m, 2'b00, 2'(md)});
      if (md == 1 || md == 2) syn_q.push_back(~m);
      @(posedge CLOCK_IN);
      FREQ_LOCK_IN  <= 1'b1;
      PHASE_LOCK_IN <= 1'b1;
      repeat (6) @(posedge CLOCK_IN);
    end
    wr(A_SYN, {m, 4'h4});
    wr(A_UPD, 8'h01);
    syn_q.push_back(~m);
    @(posedge CLOCK_IN);
    REF_SYNC_IN <= 1'b1;
    repeat (6) @(posedge CLOCK_IN);
    REF_SYNC_IN <= 1'b0;
    repeat (4) @(posedge CLOCK_IN);
    chk(33'(apb_q.size() + syn_q.size()), 33'h0);
    end_sim();
  end
endmodule : tb_dpsm_top
`default_nettype wire
